/* File: common/dac_pkg.sv */
// Constants for the dust alarm and auto-setup controller.
// Assumes a 200 MHz system clock and a 32-bit Avalon-MM register port.
package dac_pkg;
   // Timebase.
   localparam int unsigned CLK_HZ         = 200_000_000;
   localparam int unsigned TICK_S         = 1;
   localparam int unsigned TICK_CYC       = CLK_HZ * TICK_S;
   // Register byte offsets.
   localparam logic [5:0]  OFS_AVG        = 6'h00;
   localparam logic [5:0]  OFS_DELAY      = 6'h04;
   localparam logic [5:0]  OFS_HYST       = 6'h08;
   localparam logic [5:0]  OFS_ALERT      = 6'h0C;
   localparam logic [5:0]  OFS_ALARM      = 6'h10;
   localparam logic [5:0]  OFS_CTRL       = 6'h14;
   localparam logic [5:0]  OFS_STATUS     = 6'h18;
   localparam logic [5:0]  OFS_LOOP_FS    = 6'h1C;
   localparam logic [5:0]  OFS_LOOP_ZERO  = 6'h20;
   localparam logic [5:0]  OFS_LEVEL_REF  = 6'h24;
   // Control register bit positions.
   localparam int unsigned CTRL_START     = 0;
   localparam int unsigned CTRL_LOCK      = 1;
   localparam int unsigned CTRL_MODBUS    = 2;
   localparam int unsigned CTRL_NET_OK    = 3;
   localparam int unsigned CTRL_BOOT_FAIL = 4;
   localparam int unsigned CTRL_LEAK      = 5;
   // Defaults and limits, seconds; then threshold and setup multipliers.
   localparam logic [15:0] AVG_DEF        = 16'h0064;
   localparam logic [15:0] AVG_MAX        = 16'h1770;
   localparam logic [15:0] DELAY_DEF      = 16'h001E;
   localparam logic [15:0] DELAY_MAX      = 16'hEA60;
   localparam logic [15:0] HYST_DEF       = 16'h0000;
   localparam logic [15:0] HYST_MAX       = 16'h0019;
   localparam logic [15:0] BOOT_WIN_S     = 16'h000F;
   localparam logic [15:0] BOOT_RUN_S     = 16'h0005;
   localparam logic [15:0] SETUP_HOLD_S   = 16'h0001;
   localparam logic [4:0]  ALERT_MULT     = 5'h05;
   localparam logic [4:0]  ALARM_MULT     = 5'h14;
   localparam logic [3:0]  SETUP_MULT     = 4'hA;
   // Blink rates, half periods at 200 MHz: 1 Hz, 10 Hz, 0.5 Hz slow.
   localparam int unsigned HALF_1HZ       = CLK_HZ / 2;
   localparam int unsigned HALF_10HZ      = CLK_HZ / 20;
   localparam int unsigned HALF_SLOW      = CLK_HZ;
   typedef enum logic [1:0] {DAC_LIGHT_ON, DAC_LIGHT_SLOW, DAC_LIGHT_BOOT, DAC_LIGHT_FAULT} dac_light_t;
endpackage : dac_pkg

/* File: hdl/dac_ctrl.sv */
// Dust alarm timing, auto-setup sequencer and cover light driver.
// Assumes an Avalon-MM master on clk, an asynchronous setup pin and a level sample from the front end.
//
// What this block does
// - Averaging time defaults to 100 s, settable 0 to 6000 s.
// - Thresholds reset to all ones until auto-setup loads 5x and 20x reference; host may rewrite them.
// - Alarm lines wait a delay, default 30 s, range 0 to 60000 s.
// - Alarm lines change no faster than hysteresis time, default 0, max 25 s.
// - Auto-setup takes the learned level as the 5 percent loop point.
// - Auto-setup sets alert to 5x and alarm to 20x learned level.
// - Auto-setup sets loop full scale to 20x and zero point to zero.
// - Auto-setup restores averaging, delay and hysteresis defaults.
// - Cover light blinks slowly while auto-setup runs.
// - A remote start command also begins auto-setup.
// - Auto-setup lasts ten averaging times, then blinking stops.
// - Setup input within 15 s of power-on runs a boot check instead.
// - Boot check blinks the cover light at 1 Hz.
// - Failed boot check shows the 10 Hz fault pattern.
// - Permanent leakage to ground shows the 10 Hz fault pattern.
// - Comes up in vendor protocol mode; Modbus needs network parameters first.
// - Parameters may be changed from USB, RS-485 or radio alike.
// - Two alarm lines: off 00, normal 01, alert 10, alarm 11.
// - A lock refuses parameter writes and remote auto-setup starts; the setup pin still starts auto-setup.
`timescale 1ns/1ps
module dac_ctrl #(
   parameter int unsigned TICK_CYCLES = dac_pkg::TICK_CYC,
   parameter int unsigned LEVEL_W     = 16
) (
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Avalon-MM slave.
   input  wire logic [5:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   output logic      [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   // Measurement and pins.
   input  wire logic [LEVEL_W-1:0]   dust_level,
   input  wire logic                 setup_pin,
   output logic                      first_alarm_line,
   output logic                      second_alarm_line,
   output logic                      cover_light,
   output dac_pkg::dac_light_t       light_mode
);
   import dac_pkg::*;

   initial begin
      if (TICK_CYCLES < CLK_HZ / HALF_10HZ || LEVEL_W < 4 || LEVEL_W > 26) $error("dac_ctrl: bad parameter");
   end

   typedef enum logic [2:0] {DAC_IDLE, DAC_BOOT, DAC_BOOT_FAIL, DAC_SETUP, DAC_RUN} dac_state_t;

   ////////////////////////////////////////////////////////////////////////////////
   logic [1:0]  rst_sync;
   logic        rst_ok_n;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) rst_sync <= 2'h0;
      else        rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_ok_n = rst_sync[1];

   // One-second tick.
   logic [31:0] tick_cnt_reg;
   logic        tick;
   assign tick = (tick_cnt_reg == TICK_CYCLES - 1);
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n)  tick_cnt_reg <= 32'h0;
      else if (tick)  tick_cnt_reg <= 32'h0;
      else            tick_cnt_reg <= tick_cnt_reg + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Setup pin: three stages, change counted when the last two agree.
   logic [2:0]  pin_sync;
   logic        pin_level_reg;
   logic [15:0] pin_hold_reg;
   logic        pin_req;
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         pin_sync      <= 3'h0;
         pin_level_reg <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[1:0], setup_pin};
         if (pin_sync[1] == pin_sync[2]) pin_level_reg <= pin_sync[2];
      end
   end
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n)          pin_hold_reg <= 16'h0;
      else if (!pin_level_reg) pin_hold_reg <= 16'h0;
      else if (tick && pin_hold_reg != 16'hFFFF) pin_hold_reg <= pin_hold_reg + 16'h1;
   end
   // One request per press, once held a full second.
   // The count reaches the hold time at the first tick of level high; the request waits for the next tick, a whole second later.
   assign pin_req = tick && pin_level_reg && (pin_hold_reg == SETUP_HOLD_S);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [15:0]        avg_reg, delay_reg, hyst_reg;
   logic [LEVEL_W+4:0] alert_reg, alarm_reg, loop_fs_reg, loop_zero_reg;
   logic [LEVEL_W-1:0] ref_reg, ref_new;
   logic               lock_reg, modbus_reg, net_ok_reg, boot_fail_reg, leak_reg;
   logic               wr, remote_req;
   dac_state_t         state_reg;
   logic               setup_done;
   assign wr         = avs_write && !lock_reg;
   assign remote_req = avs_write && !lock_reg && avs_address == OFS_CTRL && avs_writedata[CTRL_START];
   logic               rd_done_reg;
   // Reads wait one cycle so that the registered data stands when waitrequest drops.
   assign avs_waitrequest = avs_read && !rd_done_reg;
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) rd_done_reg <= 1'b0;
      else           rd_done_reg <= avs_read && !rd_done_reg;
   end

   // Settings shared by all ports; the link path is outside this block.
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         avg_reg       <= AVG_DEF;
         delay_reg     <= DELAY_DEF;
         hyst_reg      <= HYST_DEF;
         alert_reg     <= '1;
         alarm_reg     <= '1;
         loop_fs_reg   <= '1;
         loop_zero_reg <= '0;
      end else if (setup_done) begin
         avg_reg       <= AVG_DEF;
         delay_reg     <= DELAY_DEF;
         hyst_reg      <= HYST_DEF;
         alert_reg     <= (LEVEL_W+5)'(ref_new) * (LEVEL_W+5)'(ALERT_MULT);
         alarm_reg     <= (LEVEL_W+5)'(ref_new) * (LEVEL_W+5)'(ALARM_MULT);
         loop_fs_reg   <= (LEVEL_W+5)'(ref_new) * (LEVEL_W+5)'(ALARM_MULT);
         loop_zero_reg <= '0;
      end else if (wr) begin
         case (avs_address)
            OFS_AVG:       if (avs_writedata[15:0] <= AVG_MAX)   avg_reg   <= avs_writedata[15:0];
            OFS_DELAY:     if (avs_writedata[15:0] <= DELAY_MAX) delay_reg <= avs_writedata[15:0];
            OFS_HYST:      if (avs_writedata[15:0] <= HYST_MAX)  hyst_reg  <= avs_writedata[15:0];
            OFS_ALERT:     alert_reg     <= avs_writedata[LEVEL_W+4:0];
            OFS_ALARM:     alarm_reg     <= avs_writedata[LEVEL_W+4:0];
            OFS_LOOP_FS:   loop_fs_reg   <= avs_writedata[LEVEL_W+4:0];
            OFS_LOOP_ZERO: loop_zero_reg <= avs_writedata[LEVEL_W+4:0];
            default: ;
         endcase
      end
   end

   // Control bits; the lock itself can always be cleared and set.
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         lock_reg      <= 1'b0;
         modbus_reg    <= 1'b0;
         net_ok_reg    <= 1'b0;
         boot_fail_reg <= 1'b0;
         leak_reg      <= 1'b0;
      end else if (avs_write && avs_address == OFS_CTRL) begin
         lock_reg <= avs_writedata[CTRL_LOCK];
         if (!lock_reg) begin
            net_ok_reg    <= avs_writedata[CTRL_NET_OK];
            modbus_reg    <= avs_writedata[CTRL_MODBUS] && (avs_writedata[CTRL_NET_OK] || net_ok_reg);
            boot_fail_reg <= avs_writedata[CTRL_BOOT_FAIL];
            leak_reg      <= avs_writedata[CTRL_LEAK];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) avs_readdata <= 32'h0;
      else if (avs_read && !rd_done_reg) begin
         case (avs_address)
            OFS_AVG:       avs_readdata <= {16'h0, avg_reg};
            OFS_DELAY:     avs_readdata <= {16'h0, delay_reg};
            OFS_HYST:      avs_readdata <= {16'h0, hyst_reg};
            OFS_ALERT:     avs_readdata <= 32'(alert_reg);
            OFS_ALARM:     avs_readdata <= 32'(alarm_reg);
            OFS_CTRL:      avs_readdata <= 32'({leak_reg, boot_fail_reg, net_ok_reg, modbus_reg, lock_reg, 1'b0});
            OFS_STATUS:    avs_readdata <= 32'({first_alarm_line, second_alarm_line, state_reg});
            OFS_LOOP_FS:   avs_readdata <= 32'(loop_fs_reg);
            OFS_LOOP_ZERO: avs_readdata <= 32'(loop_zero_reg);
            OFS_LEVEL_REF: avs_readdata <= 32'(ref_reg);
            default:       avs_readdata <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer.
   logic [19:0]        seq_cnt_reg;
   logic [LEVEL_W+12:0] acc_reg;
   logic [15:0]        up_reg;
   logic               start;
   assign start      = pin_req || remote_req;
   assign setup_done = state_reg == DAC_SETUP && tick &&
                       seq_cnt_reg + 20'h1 >= 20'(avg_reg) * 20'(SETUP_MULT);
   // Mean of the samples including this tick's, so thresholds and reference load together.
   assign ref_new = LEVEL_W'((acc_reg + (LEVEL_W+13)'(dust_level)) / (LEVEL_W+13)'(seq_cnt_reg + 20'h1));

   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) up_reg <= 16'h0;
      else if (tick && up_reg != 16'hFFFF) up_reg <= up_reg + 16'h1;
   end

   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         state_reg   <= DAC_IDLE;
         seq_cnt_reg <= 20'h0;
         acc_reg     <= '0;
         ref_reg     <= '0;
      end else begin
         case (state_reg)
            DAC_IDLE, DAC_RUN: begin
               if (pin_level_reg && up_reg < BOOT_WIN_S && state_reg == DAC_IDLE) begin
                  state_reg   <= DAC_BOOT;
                  seq_cnt_reg <= 20'h0;
               end else if (start && up_reg >= BOOT_WIN_S) begin
                  state_reg   <= DAC_SETUP;
                  seq_cnt_reg <= 20'h0;
                  acc_reg     <= '0;
               end else if (state_reg == DAC_IDLE && up_reg >= BOOT_WIN_S) state_reg <= DAC_RUN;
            end
            DAC_BOOT: begin
               if (tick) seq_cnt_reg <= seq_cnt_reg + 20'h1;
               if (boot_fail_reg) state_reg <= DAC_BOOT_FAIL;
               else if (tick && seq_cnt_reg == 20'(BOOT_RUN_S) - 20'h1) state_reg <= DAC_RUN;
            end
            DAC_BOOT_FAIL: state_reg <= DAC_BOOT_FAIL;
            DAC_SETUP: begin
               if (tick) begin
                  seq_cnt_reg <= seq_cnt_reg + 20'h1;
                  acc_reg     <= acc_reg + (LEVEL_W+13)'(dust_level);
               end
               if (setup_done) begin
                  ref_reg   <= ref_new;
                  state_reg <= DAC_RUN;
               end
            end
            default: state_reg <= DAC_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alarm lines: raw level, delayed rise, hysteresis between changes.
   logic [1:0]  raw_lvl, out_reg;
   logic [15:0] dly_reg, hys_cnt_reg;
   always_comb begin
      if ((LEVEL_W+5)'(dust_level) >= alarm_reg)      raw_lvl = 2'h2;
      else if ((LEVEL_W+5)'(dust_level) >= alert_reg) raw_lvl = 2'h1;
      else                                            raw_lvl = 2'h0;
   end
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         out_reg     <= 2'h0;
         dly_reg     <= 16'h0;
         hys_cnt_reg <= 16'h0;
      end else begin
         if (tick && hys_cnt_reg != 16'hFFFF) hys_cnt_reg <= hys_cnt_reg + 16'h1;
         if (raw_lvl <= out_reg) dly_reg <= 16'h0;
         else if (tick && dly_reg != 16'hFFFF) dly_reg <= dly_reg + 16'h1;
         if (raw_lvl != out_reg && hys_cnt_reg >= hyst_reg &&
             (raw_lvl < out_reg || dly_reg >= delay_reg)) begin
            out_reg     <= raw_lvl;
            hys_cnt_reg <= 16'h0;
            dly_reg     <= 16'h0;
         end
      end
   end
   logic run_ok;
   assign run_ok = state_reg == DAC_RUN && !leak_reg;
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         first_alarm_line  <= 1'b0;
         second_alarm_line <= 1'b0;
      end else begin
         first_alarm_line  <= run_ok && out_reg != 2'h0;
         second_alarm_line <= run_ok && out_reg != 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Cover light.
   logic [31:0] blink_cnt_reg;
   logic [31:0] half;
   // Half periods follow the tick length, so a shortened second scales the blinking too.
   localparam int unsigned BLINK_FAULT = TICK_CYCLES / (CLK_HZ / HALF_10HZ);
   localparam int unsigned BLINK_BOOT  = TICK_CYCLES / (CLK_HZ / HALF_1HZ);
   localparam int unsigned BLINK_SLOW  = TICK_CYCLES / (CLK_HZ / HALF_SLOW);
   always_comb begin
      if (leak_reg || state_reg == DAC_BOOT_FAIL) light_mode = DAC_LIGHT_FAULT;
      else if (state_reg == DAC_BOOT)             light_mode = DAC_LIGHT_BOOT;
      else if (state_reg == DAC_SETUP)            light_mode = DAC_LIGHT_SLOW;
      else                                        light_mode = DAC_LIGHT_ON;
      case (light_mode)
         DAC_LIGHT_FAULT: half = BLINK_FAULT;
         DAC_LIGHT_BOOT:  half = BLINK_BOOT;
         default:         half = BLINK_SLOW;
      endcase
   end
   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         blink_cnt_reg <= 32'h0;
         cover_light   <= 1'b0;
      end else if (light_mode == DAC_LIGHT_ON) begin
         blink_cnt_reg <= 32'h0;
         cover_light   <= state_reg == DAC_RUN;
      end else if (blink_cnt_reg >= half - 32'h1) begin
         blink_cnt_reg <= 32'h0;
         cover_light   <= !cover_light;
      end else blink_cnt_reg <= blink_cnt_reg + 32'h1;
   end

   a_lock_blocks: assert property (@(posedge clk) disable iff (!rst_ok_n)
      (lock_reg && avs_write && !setup_done) |=> $stable(avg_reg) && $stable(delay_reg) && $stable(hyst_reg))
      else $error("locked write changed a setting");
   a_setup_restores: assert property (@(posedge clk) disable iff (!rst_ok_n)
      setup_done |=> (avg_reg == AVG_DEF && hyst_reg == HYST_DEF && delay_reg == DELAY_DEF))
      else $error("defaults not restored");
   a_thresh_ratio: assert property (@(posedge clk) disable iff (!rst_ok_n)
      setup_done |=> alarm_reg == (LEVEL_W+5)'(ref_reg) * (LEVEL_W+5)'(ALARM_MULT) &&
                     alert_reg == (LEVEL_W+5)'(ref_reg) * (LEVEL_W+5)'(ALERT_MULT) &&
                     loop_fs_reg == alarm_reg && loop_zero_reg == '0)
      else $error("thresholds or loop scale wrong after setup");
   a_line_code: assert property (@(posedge clk) disable iff (!rst_ok_n)
      !(state_reg == DAC_RUN) |=> !first_alarm_line && !second_alarm_line)
      else $error("alarm lines active outside run");
   a_setup_light: assert property (@(posedge clk) disable iff (!rst_ok_n)
      state_reg == DAC_SETUP && !leak_reg |-> light_mode == DAC_LIGHT_SLOW)
      else $error("setup not blinking slowly");
   a_fault_light: assert property (@(posedge clk) disable iff (!rst_ok_n)
      leak_reg |-> light_mode == DAC_LIGHT_FAULT)
      else $error("leak not showing fault");
   a_hyst_spacing: assert property (@(posedge clk) disable iff (!rst_ok_n)
      out_reg != $past(out_reg) |-> $past(hys_cnt_reg) >= $past(hyst_reg))
      else $error("alarm changed inside hysteresis");
   a_avg_range: assert property (@(posedge clk) disable iff (!rst_ok_n)
      avg_reg <= AVG_MAX && delay_reg <= DELAY_MAX)
      else $error("setting out of range");
endmodule : dac_ctrl

/* File: bench/dac_host_model.sv */
// Host and operator model: Avalon-MM master tasks and the wired setup input.
// Assumes read data stands at the edge where waitrequest is seen low, and a pull-down on the setup wire.
`timescale 1ns/1ps
module dac_host_model (
   // Clock.
   input  wire logic        clk,
   // Avalon-MM master.
   output logic      [5:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest,
   // Operator wiring.
   output logic             setup_pin
);
   initial begin
      avs_address   = 6'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h00000000;
      setup_pin     = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Writes look the same whichever port the host uses; a released data bus shows garbage.
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      avs_write     <= 1'b0;
      avs_writedata <= ~d;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_read    <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      d = avs_readdata;
      avs_read    <= 1'b0;
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   // The operator ties the setup wire high for a while, then releases it.
   task automatic press(input int unsigned cyc);
      @(posedge clk);
      setup_pin <= 1'b1;
      repeat (cyc) @(posedge clk);
      setup_pin <= 1'b0;
   endtask : press
endmodule : dac_host_model

/* File: bench/dust_alarm_autosetup_ctrl_tb_top.sv */
// Self-checking bench for the alarm timing and auto-setup controller.
// Assumes a 20-cycle second; tk() waits are counted in those ticks, short waits in clock cycles.
`timescale 1ns/1ps
module dust_alarm_autosetup_ctrl_tb_top;
   import dac_pkg::*;
   localparam int unsigned TK = 20;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] dust_level = 16'h0000;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        setup_pin;
   logic        first_alarm_line;
   logic        second_alarm_line;
   logic        cover_light;
   dac_light_t  light_mode;
   logic [31:0] rv;
   int          fail_count = 0;
   int          checks = 0;
   always #2.5 clk = ~clk;
   dac_ctrl #(.TICK_CYCLES(TK), .LEVEL_W(16)) dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .dust_level(dust_level), .setup_pin(setup_pin),
      .first_alarm_line(first_alarm_line), .second_alarm_line(second_alarm_line), .cover_light(cover_light),
      .light_mode(light_mode));
   dac_host_model host_u (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .setup_pin(setup_pin));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
      host_u.rd(a, rv);
      chk({16'h0000, rv[15:0]}, {16'h0000, exp});
   endtask : rchk
   task automatic lchk(input dac_light_t m);
      chk({30'h0, light_mode}, {30'h0, m});
   endtask : lchk
   task automatic nchk(input logic [1:0] exp);
      chk({30'h0, first_alarm_line, second_alarm_line}, {30'h0, exp});
   endtask : nchk
   task automatic tk(input int unsigned n);
      repeat (n * TK) @(posedge clk);
   endtask : tk
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : do_reset
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      rchk(OFS_AVG, 16'h0064);
      rchk(OFS_DELAY, 16'h001E);
      rchk(OFS_HYST, 16'h0000);
      host_u.rd(OFS_CTRL, rv);
      chk({31'h0, rv[CTRL_MODBUS]}, 32'h00000000);
      nchk(2'h0);
      // Setup wire raised inside the power-on window.
      host_u.press(45);
      repeat (20) @(posedge clk);
      lchk(DAC_LIGHT_BOOT);
      rv[0] = cover_light;
      repeat (10) @(posedge clk);
      chk({31'h0, cover_light}, {31'h0, ~rv[0]});
      host_u.wr(OFS_CTRL, 32'h1 << CTRL_BOOT_FAIL);
      repeat (4) @(posedge clk);
      lchk(DAC_LIGHT_FAULT);
      rv[0] = cover_light;
      @(posedge clk);
      chk({31'h0, cover_light}, {31'h0, ~rv[0]});
      do_reset();
      tk(16);
      host_u.wr(OFS_AVG, 32'h00001771);
      rchk(OFS_AVG, 16'h0064);
      host_u.wr(OFS_AVG, 32'h00001770);
      rchk(OFS_AVG, 16'h1770);
      host_u.wr(OFS_DELAY, 32'h0000EA60);
      rchk(OFS_DELAY, 16'hEA60);
      host_u.wr(OFS_HYST, 32'h0000001A);
      rchk(OFS_HYST, 16'h0000);
      host_u.wr(OFS_HYST, 32'h00000019);
      rchk(OFS_HYST, 16'h0019);
      // An unmapped write must leave the registers alone.
      host_u.wr(6'h3C, 32'h00000007);
      rchk(OFS_AVG, 16'h1770);
      host_u.wr(OFS_CTRL, 32'h1 << CTRL_MODBUS);
      host_u.rd(OFS_CTRL, rv);
      chk({31'h0, rv[CTRL_MODBUS]}, 32'h00000000);
      host_u.wr(OFS_CTRL, (32'h1 << CTRL_MODBUS) | (32'h1 << CTRL_NET_OK));
      host_u.rd(OFS_CTRL, rv);
      chk({31'h0, rv[CTRL_MODBUS]}, 32'h00000001);
      host_u.wr(OFS_CTRL, 32'h1 << CTRL_LEAK);
      repeat (4) @(posedge clk);
      lchk(DAC_LIGHT_FAULT);
      host_u.wr(OFS_CTRL, 32'h1 << CTRL_LOCK);
      host_u.wr(OFS_AVG, 32'h00000002);
      rchk(OFS_AVG, 16'h1770);
      host_u.wr(OFS_CTRL, 32'h00000003);
      tk(1);
      chk({31'h0, light_mode == DAC_LIGHT_SLOW}, 32'h0);
      host_u.wr(OFS_CTRL, 32'h00000000);
      // Remote start with a two-second averaging time.
      host_u.wr(OFS_AVG, 32'h00000002);
      dust_level <= 16'd40;
      host_u.wr(OFS_CTRL, 32'h1 << CTRL_START);
      repeat (4) @(posedge clk);
      lchk(DAC_LIGHT_SLOW);
      rv[0] = cover_light;
      repeat (20) @(posedge clk);
      chk({31'h0, cover_light}, {31'h0, ~rv[0]});
      tk(17);
      lchk(DAC_LIGHT_SLOW);
      tk(4);
      chk({31'h0, light_mode == DAC_LIGHT_SLOW}, 32'h0);
      chk({31'h0, cover_light}, 32'h00000001);
      rchk(OFS_ALERT, 16'd200);
      rchk(OFS_ALARM, 16'd800);
      rchk(OFS_LOOP_FS, 16'd800);
      rchk(OFS_LOOP_ZERO, 16'd0);
      rchk(OFS_LEVEL_REF, 16'd40);
      rchk(OFS_AVG, 16'h0064);
      rchk(OFS_DELAY, 16'h001E);
      rchk(OFS_HYST, 16'h0000);
      // Wired start: a short glitch is ignored, a held press starts.
      host_u.wr(OFS_AVG, 32'h00000001);
      host_u.press(5);
      tk(3);
      chk({31'h0, light_mode == DAC_LIGHT_SLOW}, 32'h0);
      host_u.press(45);
      repeat (10) @(posedge clk);
      lchk(DAC_LIGHT_SLOW);
      tk(12);
      chk({31'h0, light_mode == DAC_LIGHT_SLOW}, 32'h0);
      // Alarm line timing with averaging off.
      host_u.wr(OFS_AVG, 32'h00000000);
      host_u.wr(OFS_DELAY, 32'h00000002);
      tk(2);
      nchk(2'h1);
      dust_level <= 16'd300;
      repeat (15) @(posedge clk);
      nchk(2'h1);
      tk(3);
      nchk(2'h2);
      dust_level <= 16'd900;
      tk(3);
      nchk(2'h3);
      host_u.wr(OFS_DELAY, 32'h00000000);
      host_u.wr(OFS_HYST, 32'h00000004);
      tk(5);
      dust_level <= 16'd40;
      tk(1);
      nchk(2'h1);
      dust_level <= 16'd300;
      tk(2);
      nchk(2'h1);
      tk(4);
      nchk(2'h2);
      wrap_up();
   end
endmodule : dust_alarm_autosetup_ctrl_tb_top
